// *** crc_pkg.sv ***
package crc_pkg;
	localparam int NREG = 8;
	localparam int NTOT = 9;
	localparam int LUT_REG = 8;
	localparam int DW = 32;
	localparam int AW = 12;

	localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
	localparam logic [AW-1:0] ADDR_CFG = 12'h004;
	localparam logic [AW-1:0] ADDR_LOAD = 12'h008;
	localparam logic [AW-1:0] ADDR_STAT = 12'h00C;
	localparam logic [AW-1:0] ADDR_ADD = 12'h010;
	localparam logic [AW-1:0] ADDR_SUM = 12'h014;

	localparam int CE1_BIT = 0;
	localparam int CE2_BIT = 1;
	localparam int CLRA_BIT = 2;
	localparam int CLRB_BIT = 3;
	localparam int SCLR_BIT = 4;
	localparam int SLOAD_BIT = 5;
	localparam int ADD_EN_BIT = 6;
	localparam int CTRL_W = 7;
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h03;

	localparam int CFG_W = 4;
	localparam int CFG_CLK = 0;
	localparam int CFG_CLR = 1;
	localparam int CFG_INV = 2;
	localparam int CFG_SYNC = 3;
	localparam logic [DW-1:0] CFG_RST = 32'h0000_0000;

	localparam logic [NTOT-1:0] LOAD_RST = 9'h000;
	localparam int OPA_LSB = 0;
	localparam int OPB_LSB = 8;
	localparam int OP_W = 8;
	localparam logic [15:0] ADD_RST = 16'h0000;

	localparam int STAT_Q_LSB = 0;
	localparam int STAT_GRST_BIT = 9;
	localparam int STAT_CE_LSB = 10;

	localparam logic [1:0] DIV2_LAST = 2'h3;
	localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;
endpackage : crc_pkg

// *** crc_top.sv ***
// Summary of operation
// - register clears come from cluster-wide clear lines, never a private source.
// - clear forces a register to zero regardless of data or clock tick.
// - each cluster has only two clear sources; each register picks one.
// - preset is emulated by inverting register data in and data out.
// - the active-low global reset clears every register.
// - global reset beats clock enable, clear, sync load and sync clear.
// - global reset acts only when the build option enables it.
// - each cluster clock is paired with its own clock enable.
// - clock enable gates the cluster clock tick itself.
// - registers sharing a clock and enable pair use one gated tick.
// - unused adder inputs are held at logic low.
// - the lookup register follows register 0's clock, enable and clear.
// - sync clear and load reach registers 0-7; each may ignore them, and the lookup register always does.
module crc_top
	import crc_pkg::*;
#(
	parameter bit RESET_ENABLE = 1'b1
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [AW-1:0] PADDR,
	input wire logic [DW-1:0] PWDATA,
	output logic [DW-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic GLOBAL_RESET_N,
	input wire logic [NTOT-1:0] D_IN,
	output logic [NTOT-1:0] Q_OUT,
	output logic [1:0] GATED_TICK,
	output logic [OP_W-1:0] ADDER_A,
	output logic [OP_W-1:0] ADDER_B,
	output logic [OP_W:0] ADDER_SUM
);
	logic [CTRL_W-1:0] ctrl_reg;
	logic [DW-1:0] cfg_reg;
	logic [NTOT-1:0] load_reg;
	logic [15:0] add_reg;
	logic [DW-1:0] prdata_reg;
	logic grst_meta_reg, grst_sync_reg;
	logic [NTOT-1:0] din_meta_reg, din_sync_reg;
	logic [1:0] div_reg;
	logic [NTOT-1:0] store_reg, store_next;
	logic [NTOT-1:0] q_reg;
	logic [OP_W-1:0] adda_reg, addb_reg;
	logic [OP_W:0] sum_reg;
	logic glob_rst;

	// apb decode
	wire setup_rd = PSEL && !PENABLE && !PWRITE;
	wire acc_wr = PSEL && PENABLE && PWRITE;
	wire hit_ctrl = PADDR == ADDR_CTRL;
	wire hit_cfg = PADDR == ADDR_CFG;
	wire hit_load = PADDR == ADDR_LOAD;
	wire hit_stat = PADDR == ADDR_STAT;
	wire hit_add = PADDR == ADDR_ADD;
	wire hit_sum = PADDR == ADDR_SUM;
	wire mapped = hit_ctrl | hit_cfg | hit_load | hit_stat | hit_add | hit_sum;
	wire [DW-1:0] rd_mux = hit_ctrl ? {{(DW-CTRL_W){1'b0}}, ctrl_reg} :
		hit_cfg ? cfg_reg :
		hit_load ? {{(DW-NTOT){1'b0}}, load_reg} :
		hit_stat ? {{(DW-12){1'b0}}, ctrl_reg[CE2_BIT:CE1_BIT], glob_rst, q_reg} :
		hit_add ? {16'h0000, add_reg} :
		hit_sum ? {{(DW-OP_W-1){1'b0}}, sum_reg} : ZERO_WORD;

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA = prdata_reg;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prdata_reg <= ZERO_WORD;
		end else if (setup_rd) begin
			prdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= CTRL_RST;
			cfg_reg <= CFG_RST;
			load_reg <= LOAD_RST;
			add_reg <= ADD_RST;
		end else if (acc_wr) begin
			if (hit_ctrl) ctrl_reg <= PWDATA[CTRL_W-1:0];
			if (hit_cfg) cfg_reg <= PWDATA;
			if (hit_load) load_reg <= PWDATA[NTOT-1:0];
			if (hit_add) add_reg <= PWDATA[15:0];
		end
	end

	// pin synchronisers
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			grst_meta_reg <= 1'b1;
			grst_sync_reg <= 1'b1;
			din_meta_reg <= LOAD_RST;
			din_sync_reg <= LOAD_RST;
		end else begin
			grst_meta_reg <= GLOBAL_RESET_N;
			grst_sync_reg <= grst_meta_reg;
			din_meta_reg <= D_IN;
			din_sync_reg <= din_meta_reg;
		end
	end

	assign glob_rst = RESET_ENABLE && !grst_sync_reg;

	// cluster clocks: clock 1 every cycle, clock 2 every fourth cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end

	wire [1:0] clk_tick = {div_reg == DIV2_LAST, 1'b1};
	wire [1:0] clk_en = {ctrl_reg[CE2_BIT], ctrl_reg[CE1_BIT]};
	wire [1:0] gated = clk_tick & clk_en;
	wire [1:0] clr_src = {ctrl_reg[CLRB_BIT], ctrl_reg[CLRA_BIT]};
	wire sclr = ctrl_reg[SCLR_BIT];
	wire sload = ctrl_reg[SLOAD_BIT];
	assign GATED_TICK = gated;

	logic [NTOT-1:0] tick_sel, clr_sel, inv_sel, sync_sel;

	genvar gi;
	generate
		for (gi = 0; gi < NTOT; gi++) begin : g_reg
			localparam int CI = (gi == LUT_REG) ? 0 : gi;
			wire [CFG_W-1:0] cfg = cfg_reg[CI*CFG_W +: CFG_W];
			wire tick = gated[cfg[CFG_CLK]];
			wire clr = clr_src[cfg[CFG_CLR]];
			wire inv = (gi == LUT_REG) ? 1'b0 : cfg[CFG_INV];
			wire hon = (gi == LUT_REG) ? 1'b0 : cfg[CFG_SYNC];
			assign tick_sel[gi] = tick;
			assign clr_sel[gi] = clr;
			assign inv_sel[gi] = inv;
			assign sync_sel[gi] = hon;
			always_comb begin
				if (glob_rst) begin
					store_next[gi] = 1'b0;
				end else if (clr) begin
					store_next[gi] = 1'b0;
				end else if (tick && hon && sclr) begin
					store_next[gi] = 1'b0;
				end else if (tick && hon && sload) begin
					store_next[gi] = load_reg[gi] ^ inv;
				end else if (tick) begin
					store_next[gi] = din_sync_reg[gi] ^ inv;
				end else begin
					store_next[gi] = store_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			store_reg <= LOAD_RST;
			q_reg <= LOAD_RST;
		end else begin
			store_reg <= store_next;
			q_reg <= store_next ^ inv_sel;
		end
	end
	assign Q_OUT = q_reg;

	// adder operands forced low when idle
	wire add_en = ctrl_reg[ADD_EN_BIT];
	wire [OP_W-1:0] opa = add_en ? add_reg[OPA_LSB +: OP_W] : 8'h00;
	wire [OP_W-1:0] opb = add_en ? add_reg[OPB_LSB +: OP_W] : 8'h00;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			adda_reg <= 8'h00;
			addb_reg <= 8'h00;
			sum_reg <= 9'h000;
		end else begin
			adda_reg <= opa;
			addb_reg <= opb;
			sum_reg <= {1'b0, adda_reg} + {1'b0, addb_reg};
		end
	end
	assign ADDER_A = adda_reg;
	assign ADDER_B = addb_reg;
	assign ADDER_SUM = sum_reg;

	glob_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		glob_rst |=> (store_reg == 9'h000) && (q_reg == $past(inv_sel)))
		else $error("global reset left a register set");

	reset_prio_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(glob_rst && (|gated) && sload) |=> store_reg == 9'h000)
		else $error("global reset lost to another control");

	reset_opt_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!grst_sync_reg && tick_sel[0] && !clr_sel[0] && !sclr && !sload)
		|=> store_reg[0] == (RESET_ENABLE ? 1'b0 : $past(din_sync_reg[0] ^ inv_sel[0])))
		else $error("global reset pin acted against the build option");

	clear_wins_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(clr_sel[0] && tick_sel[0]) |=> !store_reg[0])
		else $error("clear did not override clocked update");

	clear_pick_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		clr_sel[1] == (cfg_reg[CFG_W+CFG_CLR] ? ctrl_reg[CLRB_BIT] : ctrl_reg[CLRA_BIT]))
		else $error("clear source selection wrong");

	gate_stop_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!ctrl_reg[CE2_BIT] |-> !GATED_TICK[1] && (GATED_TICK[0] == ctrl_reg[CE1_BIT]))
		else $error("gated tick while enable low");

	hold_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!tick_sel[2] && !clr_sel[2] && !glob_rst) |=> $stable(store_reg[2]))
		else $error("register moved without its gated tick");

	lut_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[LUT_REG] == tick_sel[0]) && (clr_sel[LUT_REG] == clr_sel[0]))
		else $error("lookup register not tied to register 0");

	sync_skip_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[3] && !sync_sel[3] && sclr && !clr_sel[3] && !glob_rst)
		|=> store_reg[3] == $past(din_sync_reg[3] ^ inv_sel[3]))
		else $error("ignoring register obeyed sync clear");

	adder_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!add_en |=> (ADDER_A == 8'h00) && (ADDER_B == 8'h00) ##1 ADDER_SUM == 9'h000)
		else $error("idle adder inputs not low");

	clear_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		clr_sel[4] |=> !store_reg[4])
		else $error("clear left register 4 set");

	clear_none_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!ctrl_reg[CLRA_BIT] && !ctrl_reg[CLRB_BIT]) |-> (clr_sel == 9'h000))
		else $error("register cleared with no cluster clear");

	clear_both_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(ctrl_reg[CLRA_BIT] && ctrl_reg[CLRB_BIT]) |-> (clr_sel == 9'h1FF))
		else $error("register escaped both cluster clears");

	preset_view_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[1] && !sync_sel[1] && !clr_sel[1] && !glob_rst) |=> Q_OUT[1] == $past(din_sync_reg[1]))
		else $error("inverted register output differs from data");

	preset_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(clr_sel[1] && !glob_rst) |=> Q_OUT[1] == $past(inv_sel[1]))
		else $error("cleared register did not show preset level");

	reset_lut_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		glob_rst |=> !Q_OUT[LUT_REG])
		else $error("global reset left lookup register set");

	reset_sclr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(glob_rst && (|tick_sel) && sclr) |=> store_reg == 9'h000)
		else $error("global reset lost to sync clear");

	reset_ce_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(glob_rst && !ctrl_reg[CE1_BIT] && !ctrl_reg[CE2_BIT]) |=> store_reg == 9'h000)
		else $error("global reset waited for a clock enable");

	reset_noclr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(glob_rst && !(|clr_sel)) |=> store_reg == 9'h000)
		else $error("global reset needed a cluster clear");

	pin_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!GLOBAL_RESET_N) [*3] |=> !RESET_ENABLE || (store_reg == 9'h000))
		else $error("held reset pin did not clear registers");

	tick_once_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		GATED_TICK[1] |=> (!GATED_TICK[1]) [*3])
		else $error("clock 2 tick faster than its divider");

	gate_ce1_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!ctrl_reg[CE1_BIT] |-> !GATED_TICK[0])
		else $error("clock 1 ticked with its enable low");

	tick_pair_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(GATED_TICK & ~{ctrl_reg[CE2_BIT], ctrl_reg[CE1_BIT]}) == 2'h0)
		else $error("cluster clock used a foreign enable");

	hold_ce_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!ctrl_reg[CE1_BIT] && !ctrl_reg[CE2_BIT] && !(|clr_sel) && !glob_rst) |=> $stable(store_reg))
		else $error("register moved with both enables low");

	shared_tick_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(cfg_reg[CFG_CLK] == cfg_reg[CFG_W+CFG_CLK]) |-> (tick_sel[0] == tick_sel[1]))
		else $error("same clock pair gave different ticks");

	tick_moves_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[2] && !sync_sel[2] && !clr_sel[2] && !glob_rst) |=> store_reg[2] == $past(din_sync_reg[2] ^ inv_sel[2]))
		else $error("register missed its gated tick");

	adder_take_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		add_en |=> (ADDER_A == $past(add_reg[OPA_LSB +: OP_W])) && (ADDER_B == $past(add_reg[OPB_LSB +: OP_W])))
		else $error("enabled adder lost its operands");

	adder_sum_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		1'b1 |=> ADDER_SUM == ({1'b0, $past(ADDER_A)} + {1'b0, $past(ADDER_B)}))
		else $error("adder sum wrong");

	lut_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		clr_sel[0] |=> !store_reg[LUT_REG])
		else $error("lookup register missed register 0 clear");

	lut_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!tick_sel[0] && !clr_sel[0] && !glob_rst) |=> $stable(store_reg[LUT_REG]))
		else $error("lookup register moved without register 0 tick");

	lut_plain_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[0] && !clr_sel[0] && !glob_rst) |=> Q_OUT[LUT_REG] == $past(din_sync_reg[LUT_REG]))
		else $error("lookup register did not take its data");

	sload_take_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[5] && sync_sel[5] && sload && !sclr && !clr_sel[5] && !glob_rst) |=> Q_OUT[5] == $past(load_reg[5]))
		else $error("honouring register ignored sync load");

	sclr_take_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[6] && sync_sel[6] && sclr && !clr_sel[6] && !glob_rst) |=> !store_reg[6])
		else $error("honouring register ignored sync clear");

	sload_skip_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(tick_sel[7] && !sync_sel[7] && sload && !clr_sel[7] && !glob_rst) |=> Q_OUT[7] == $past(din_sync_reg[7]))
		else $error("ignoring register obeyed sync load");

	clear_load_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(clr_sel[5] && tick_sel[5] && sload) |=> !store_reg[5])
		else $error("sync load beat the clear");

	clear_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(clr_sel[6] && !tick_sel[6]) |=> !store_reg[6])
		else $error("clear waited for a gated tick");

	write_ctrl_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(acc_wr && hit_ctrl) |=> ctrl_reg == $past(PWDATA[CTRL_W-1:0]))
		else $error("control write did not land");

	read_data_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(setup_rd && hit_ctrl) |=> PRDATA == {{(DW-CTRL_W){1'b0}}, $past(ctrl_reg)})
		else $error("control read data wrong");
endmodule : crc_top

// *** crc_top_tb_top.sv ***
module crc_top_tb_top
	import crc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [AW-1:0] paddr = 12'h000;
	logic [DW-1:0] pwdata = 32'h0000_0000;
	logic grst_n = 1'b1;
	logic [NTOT-1:0] d_in = 9'h000;
	logic [DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [NTOT-1:0] q_out;
	logic [NTOT-1:0] q_off;
	logic [1:0] gtick;
	logic [OP_W-1:0] add_a;
	logic [OP_W-1:0] add_b;
	logic [OP_W:0] add_sum;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 74;
	logic [DW-1:0] exp_q[$];
	logic err_q[$];
	localparam logic [AW-1:0] ADDRS [6] = '{ADDR_CTRL, ADDR_CFG, ADDR_LOAD, ADDR_ADD, ADDR_SUM, 12'hFFC};
	localparam logic [DW-1:0] RVALS [6] = '{32'(CTRL_RST), CFG_RST, 32'(LOAD_RST), 32'(ADD_RST), ZERO_WORD, ZERO_WORD};
	crc_top dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GLOBAL_RESET_N(grst_n),
		.D_IN(d_in), .Q_OUT(q_out), .GATED_TICK(gtick), .ADDER_A(add_a), .ADDER_B(add_b), .ADDER_SUM(add_sum));
	crc_top #(.RESET_ENABLE(1'b0)) dut_off (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR(), .GLOBAL_RESET_N(grst_n),
		.D_IN(d_in), .Q_OUT(q_off), .GATED_TICK(), .ADDER_A(), .ADDER_B(), .ADDER_SUM());
	always #5 sys_clk = ~sys_clk;
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task chk(input logic [DW-1:0] e, input logic [DW-1:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR at %0t expected %h got %h", $time, e, g);
		end
	endtask : chk
	task apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		exp_q.push_back(e);
		err_q.push_back(!(a inside {ADDR_CTRL, ADDR_CFG, ADDR_LOAD, ADDR_STAT, ADDR_ADD, ADDR_SUM}));
		apb(1'b0, a, ZERO_WORD);
	endtask : rd
	task tk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tk
	function automatic logic [NTOT-1:0] sel(input logic [DW-1:0] c, input int k);
		logic [NTOT-1:0] s;
		for (int i = 0; i < NREG; i++) s[i] = c[4*i+k];
		s[LUT_REG] = (k < 2) ? c[k] : 1'b0;
		return s;
	endfunction : sel
	function automatic logic [NTOT-1:0] mix(input logic [NTOT-1:0] m, a, b);
		return (m & a) | (~m & b);
	endfunction : mix
	function automatic logic [DW-1:0] st(input logic [NTOT-1:0] q, input logic [1:0] ce, input logic g);
		return 32'(q) | (32'(g) << STAT_GRST_BIT) | (32'(ce) << STAT_CE_LSB);
	endfunction : st
	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			chk(exp_q.pop_front(), prdata);
			chk(32'(err_q.pop_front()), 32'(pslverr));
		end
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		logic [DW-1:0] cfg;
		logic [NTOT-1:0] d0, d1, inv, ld, prev;
		logic [OP_W-1:0] a, b;
		logic [7:0] n1;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (ADDRS[i]) rd(ADDRS[i], RVALS[i]);
		cfg = $random(seed);
		d0 = $random(seed);
		d1 = $random(seed);
		inv = sel(cfg, CFG_INV);
		apb(1'b1, ADDR_CFG, cfg);
		d_in <= d0;
		tk(8);
		rd(ADDR_STAT, st(d0, 2'h3, 1'b0));
		chk(32'(gtick[0]), 32'h0000_0001);
		d_in <= d1;
		apb(1'b1, ADDR_CTRL, 32'h0000_0007);
		tk(8);
		rd(ADDR_STAT, st(mix(~sel(cfg, CFG_CLR), inv, d1), 2'h3, 1'b0));
		apb(1'b1, ADDR_CTRL, 32'h0000_000B);
		tk(8);
		rd(ADDR_STAT, st(mix(sel(cfg, CFG_CLR), inv, d1), 2'h3, 1'b0));
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		tk(8);
		apb(1'b1, ADDR_CTRL, 32'h0000_0002);
		d_in <= d0;
		tk(8);
		rd(ADDR_STAT, st(mix(sel(cfg, CFG_CLK), d0, d1), 2'h2, 1'b0));
		n1 = 8'h00;
		repeat (8) begin
			tk(1);
			chk(32'(gtick[0]), ZERO_WORD);
			n1 = n1 + 8'(gtick[1]);
		end
		chk(32'(n1), 32'h0000_0002);
		apb(1'b1, ADDR_CTRL, 32'h0000_0013);
		tk(8);
		rd(ADDR_STAT, st(mix(sel(cfg, CFG_SYNC), inv, d0), 2'h3, 1'b0));
		ld = $random(seed);
		apb(1'b1, ADDR_LOAD, 32'(ld));
		apb(1'b1, ADDR_CTRL, 32'h0000_0023);
		tk(8);
		prev = mix(sel(cfg, CFG_SYNC), ld, d0);
		rd(ADDR_STAT, st(prev, 2'h3, 1'b0));
		apb(1'b1, ADDR_CTRL, 32'h0000_0020);
		grst_n <= 1'b0;
		tk(6);
		rd(ADDR_STAT, st(inv, 2'h0, 1'b1));
		chk(32'(q_off), 32'(prev));
		apb(1'b1, ADDR_CTRL, 32'h0000_0023);
		tk(8);
		rd(ADDR_STAT, st(inv, 2'h3, 1'b1));
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		tk(8);
		chk(32'(q_off), 32'(d0));
		grst_n <= 1'b1;
		a = $random(seed);
		b = $random(seed);
		apb(1'b1, ADDR_CTRL, 32'h0000_0043);
		apb(1'b1, ADDR_ADD, {16'h0000, b, a});
		tk(4);
		rd(ADDR_SUM, 32'({1'b0, a} + {1'b0, b}));
		chk(32'(add_a), 32'(a));
		chk(32'(add_sum), 32'({1'b0, a} + {1'b0, b}));
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		tk(3);
		chk(32'({add_b, add_a}), ZERO_WORD);
		chk(32'(add_sum), ZERO_WORD);
		final_report();
	end
endmodule : crc_top_tb_top
